//--- rtl/rsrpc_pkg.sv
// Constants for the rank self-refresh and channel pipeline control block.
// Assumes a Wishbone classic slave with 32-bit data and byte addressing.
package rsrpc_pkg;
	localparam int unsigned RANKS = 4;
	localparam logic [7:0] ADR_CHECK_CTRL = 8'h00;
	localparam logic [7:0] ADR_SR_CTRL_TWO = 8'h04;
	localparam logic [7:0] ADR_SR_CTRL_THREE = 8'h08;
	localparam logic [7:0] ADR_PIPE_CTRL = 8'h0C;
	localparam logic [7:0] ADR_STATUS = 8'h10;
	localparam logic [7:0] ADR_MODE_CTRL = 8'h14;
	localparam logic [7:0] RST_CHECK_CTRL = 8'h00;
	localparam logic [7:0] RST_SR_CTRL_TWO = 8'h10;
	localparam logic [7:0] RST_SR_CTRL_THREE = 8'h00;
	localparam logic [7:0] RST_PIPE_CTRL = 8'h00;
	localparam logic [1:0] RST_MODE_CTRL = 2'h0;
	localparam int unsigned POS_PAIR_ENTRY = 7;
	localparam int unsigned POS_IDLE_LO = 4;
	localparam int unsigned POS_PAIR_EXIT = 7;
	localparam int unsigned POS_PAGE_PIPE = 7;
	localparam int unsigned POS_PAGE_CLOSE_2T = 6;
	localparam int unsigned POS_CMD_2T = 5;
	localparam int unsigned POS_ACT_PRE_2T = 3;
	localparam int unsigned POS_CKE_PIPE = 0;
	localparam logic [7:0] PIPE_WR_MASK = 8'hEB;
	localparam logic [7:0] THREE_WR_MASK = 8'h87;
	localparam int unsigned IDLE_W = 3;
endpackage

//--- rtl/rsrpc_sync.sv
// Two-flop synchroniser for a bundle of level inputs.
// Assumes the inputs come from outside the clk domain.
`timescale 1ns/10ps
module rsrpc_sync #(
	parameter int unsigned W = 1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

//--- rtl/rsrpc_delay.sv
// Selectable zero, one or two stage delay line.
// Assumes sel is quasi-static configuration on the same clock.
`timescale 1ns/10ps
module rsrpc_delay #(
	parameter int unsigned W = 1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [1:0] sel,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] st1_r;
	logic [W-1:0] st2_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st1_r <= '0;
			st2_r <= '0;
		end else begin
			st1_r <= d;
			st2_r <= st1_r;
		end
	end

	always_comb begin
		case (sel)
			2'h0: q = d;
			2'h1: q = st1_r;
			default: q = st2_r;
		endcase
	end
endmodule

//--- rtl/rsrpc_top.sv
// By-rank self refresh decision and channel pipeline control.
// Assumes the refresh engine, vblank and sr request come from outside the clock domain.
// Overview of operation
// - Rank's vblank check bit set requires vertical blank before self-refresh entry.
// - Rank's request check bit set requires active self-refresh request before entry.
// - Three-bit idle count, reset one, sets consecutive idle auto-refreshes before entry.
// - Each rank enters by-rank self refresh only while its enable is set.
// - Pairwise entry bit makes ranks enter self refresh in pairs, only with fast DDR2 support.
// - Pairwise exit bit makes ranks leave in pairs, only with fast DDR2 support.
// - Page-decode pipe bit adds one clock stage to page decoding.
// - Page-close timing bit selects two-clock timing for page close commands.
// - Two-clock scheduling bit spaces commands two clocks apart.
// - Mode and cke pipe bits pick 2T, 1T or no pipe on clock enable.
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
module rsrpc_top #(
	parameter int unsigned PAGE_W = 16
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic fast_ddr2_support,
	input wire logic [3:0] auto_refresh_pulse,
	input wire logic [3:0] rank_busy,
	input wire logic [3:0] rank_wake_req,
	input wire logic gfx_vblank,
	input wire logic sr_request,
	input wire logic channel_a_clock_enable_in,
	input wire logic [PAGE_W-1:0] page_req_in,
	output logic [3:0] rank_in_self_refresh,
	output logic channel_a_clock_enable_out,
	output logic [PAGE_W-1:0] page_req_out,
	output logic page_close_2t,
	output logic cmd_sched_2t,
	output logic act_pre_2t
);
	logic [7:0] check_r;
	logic [7:0] two_r;
	logic [7:0] three_r;
	logic [7:0] pipe_r;
	logic [1:0] mode_r;
	logic [3:0] sr_r;
	logic [3:0] sr_nxt;
	logic [2:0] idle_cnt_r [0:3];
	logic [3:0] ar_s;
	logic [3:0] busy_s;
	logic [3:0] wake_s;
	logic [1:0] chk_s;
	logic [3:0] ar_d_r;
	logic [3:0] ready;
	logic [1:0] cke_sel;
	logic cke_q;
	logic [PAGE_W-1:0] page_q;
	logic wr_en;
	logic rd_en;
	logic [2:0] idle_need;
	logic wr_lane0;
	logic hit_check;
	logic hit_two;
	logic hit_three;
	logic hit_pipe;
	logic hit_status;
	logic hit_mode;
	logic [7:0] rd_byte;
	logic [3:0] ar_rise;
	logic [3:0] enter_req;
	logic [3:0] leave_req;
	logic pair_entry_on;
	logic pair_exit_on;

	// Refresh and condition inputs cross from the refresh engine and display domains
	rsrpc_sync #(.W(4)) u_sync_ar (.clk(clk), .rstn(rstn), .d(auto_refresh_pulse), .q(ar_s));
	rsrpc_sync #(.W(4)) u_sync_busy (.clk(clk), .rstn(rstn), .d(rank_busy), .q(busy_s));
	rsrpc_sync #(.W(4)) u_sync_wake (.clk(clk), .rstn(rstn), .d(rank_wake_req), .q(wake_s));
	rsrpc_sync #(.W(2)) u_sync_chk (
		.clk(clk),
		.rstn(rstn),
		.d({gfx_vblank, sr_request}),
		.q(chk_s)
	);

	assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
	// Only byte lane 0 carries register data
	assign wr_lane0 = wr_en && wb_sel_i[0];
	assign idle_need = two_r[rsrpc_pkg::POS_IDLE_LO+:rsrpc_pkg::IDLE_W];
	// Pairing only applies with fast DDR2 support
	assign pair_entry_on = two_r[rsrpc_pkg::POS_PAIR_ENTRY] && fast_ddr2_support;
	assign pair_exit_on = three_r[rsrpc_pkg::POS_PAIR_EXIT] && fast_ddr2_support;
	assign ar_rise = ar_s & ~ar_d_r;

	function automatic logic adr_is(input logic [7:0] a, input logic [7:0] target);
		adr_is = (a == target);
	endfunction

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wmask);
		merge = (old & ~wmask) | (wb_dat_i[7:0] & wmask);
	endfunction

	// One decode shared by the write and the read side
	assign hit_check = adr_is(wb_adr_i, rsrpc_pkg::ADR_CHECK_CTRL);
	assign hit_two = adr_is(wb_adr_i, rsrpc_pkg::ADR_SR_CTRL_TWO);
	assign hit_three = adr_is(wb_adr_i, rsrpc_pkg::ADR_SR_CTRL_THREE);
	assign hit_pipe = adr_is(wb_adr_i, rsrpc_pkg::ADR_PIPE_CTRL);
	assign hit_status = adr_is(wb_adr_i, rsrpc_pkg::ADR_STATUS);
	assign hit_mode = adr_is(wb_adr_i, rsrpc_pkg::ADR_MODE_CTRL);

	// Writes land on the edge that raises ack, one register per block
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			check_r <= rsrpc_pkg::RST_CHECK_CTRL;
		end else if (wr_lane0 && hit_check) begin
			check_r <= wb_dat_i[7:0];
		end
	end

	// Enables, idle count and pairwise entry are all writable
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			two_r <= rsrpc_pkg::RST_SR_CTRL_TWO;
		end else if (wr_lane0 && hit_two) begin
			two_r <= wb_dat_i[7:0];
		end
	end

	// Reserved bits 6:3 read zero and ignore writes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			three_r <= rsrpc_pkg::RST_SR_CTRL_THREE;
		end else if (wr_lane0 && hit_three) begin
			three_r <= merge(three_r, rsrpc_pkg::THREE_WR_MASK);
		end
	end

	// Bits 4 and 2 are read-only zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pipe_r <= rsrpc_pkg::RST_PIPE_CTRL;
		end else if (wr_lane0 && hit_pipe) begin
			pipe_r <= merge(pipe_r, rsrpc_pkg::PIPE_WR_MASK);
		end
	end

	// Only bit 0 steers the cke pipe; bit 1 is spare storage
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_r <= rsrpc_pkg::RST_MODE_CTRL;
		end else if (wr_lane0 && hit_mode) begin
			mode_r <= wb_dat_i[1:0];
		end
	end

	// Unmapped offsets read zero
	always_comb begin
		rd_byte = 8'h00;
		if (hit_check) begin
			rd_byte = check_r;
		end else if (hit_two) begin
			rd_byte = two_r;
		end else if (hit_three) begin
			rd_byte = three_r;
		end else if (hit_pipe) begin
			rd_byte = pipe_r;
		end else if (hit_status) begin
			rd_byte = {4'h0, sr_r};
		end else if (hit_mode) begin
			rd_byte = {6'h00, mode_r};
		end
	end

	// Read data holds until the next read so a slow master still sees it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wb_dat_o <= '0;
		end else if (rd_en) begin
			wb_dat_o <= {24'h000000, rd_byte};
		end
	end

	// One-cycle ack; the ack term stops one request being taken twice
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	// Previous refresh level; resets low like the idle pin, so no false edge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ar_d_r <= '0;
		end else begin
			ar_d_r <= ar_s;
		end
	end

	// Idle auto-refresh counters; a busy rank restarts its run of idle refreshes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 4; i++) begin
				idle_cnt_r[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (busy_s[i] || sr_r[i]) begin
					idle_cnt_r[i] <= '0;
				end else if (ar_rise[i] && idle_cnt_r[i] != 3'h7) begin
					idle_cnt_r[i] <= idle_cnt_r[i] + 3'h1;
				end
			end
		end
	end

	// A rank is ready only when every selected check holds in the same cycle
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			ready[i] = two_r[i]
				&& !busy_s[i]
				&& (idle_cnt_r[i] >= idle_need)
				&& (!check_r[2*i+1] || chk_s[1])
				&& (!check_r[2*i] || chk_s[0]);
		end
	end

	// Pairs are ranks 0/1 and 2/3; in pair mode both halves go in or neither
	always_comb begin
		enter_req = ready;
		if (pair_entry_on) begin
			for (int p = 0; p < 2; p++) begin
				if (!(ready[2*p] && ready[2*p+1])) begin
					enter_req[2*p+:2] = 2'h0;
				end
			end
		end
	end

	// A cleared enable counts as a wake, so disabling forces the rank out
	always_comb begin
		leave_req = wake_s | ~two_r[3:0];
		if (pair_exit_on) begin
			for (int p = 0; p < 2; p++) begin
				if (|leave_req[2*p+:2]) begin
					leave_req[2*p+:2] = 2'h3;
				end
			end
		end
	end

	// Exit beats entry so a rank never re-enters in the cycle it is told to leave
	assign sr_nxt = (sr_r | enter_req) & ~leave_req;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sr_r <= '0;
		end else begin
			sr_r <= sr_nxt;
		end
	end

	assign cke_sel = {1'b0, mode_r[0]} + {1'b0, pipe_r[rsrpc_pkg::POS_CKE_PIPE]};

	rsrpc_delay #(.W(1)) u_cke_pipe (
		.clk(clk),
		.rstn(rstn),
		.sel(cke_sel),
		.d(channel_a_clock_enable_in),
		.q(cke_q)
	);

	rsrpc_delay #(.W(PAGE_W)) u_page_pipe (
		.clk(clk),
		.rstn(rstn),
		.sel({1'b0, pipe_r[rsrpc_pkg::POS_PAGE_PIPE]}),
		.d(page_req_in),
		.q(page_q)
	);

	// Output flops keep every top output registered
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rank_in_self_refresh <= '0;
			channel_a_clock_enable_out <= 1'b0;
			page_req_out <= '0;
			page_close_2t <= 1'b0;
			cmd_sched_2t <= 1'b0;
			act_pre_2t <= 1'b0;
		end else begin
			rank_in_self_refresh <= sr_r;
			channel_a_clock_enable_out <= cke_q;
			page_req_out <= page_q;
			page_close_2t <= pipe_r[rsrpc_pkg::POS_PAGE_CLOSE_2T];
			cmd_sched_2t <= pipe_r[rsrpc_pkg::POS_CMD_2T];
			// Software is expected to pair this with command 2T; hardware does not force it
			act_pre_2t <= pipe_r[rsrpc_pkg::POS_ACT_PRE_2T];
		end
	end
endmodule

//--- dv/rsrpc_sva.sv
// Checker for rsrpc_top, bound to its ports.
// Assumes it shadows the registers from completed bus writes.
`timescale 1ns/10ps
module rsrpc_sva #(
	parameter int unsigned PAGE_W = 16
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic channel_a_clock_enable_in,
	input wire logic [PAGE_W-1:0] page_req_in,
	input wire logic [3:0] rank_in_self_refresh,
	input wire logic channel_a_clock_enable_out,
	input wire logic [PAGE_W-1:0] page_req_out,
	input wire logic page_close_2t,
	input wire logic cmd_sched_2t,
	input wire logic act_pre_2t
);
	logic [7:0] two_r, pipe_r;
	logic mode_r, wr;
	logic [2:0] age_r;
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
	// Age gates the checks until a new setting has flushed the pipes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			two_r <= rsrpc_pkg::RST_SR_CTRL_TWO;
			pipe_r <= 8'h00;
			mode_r <= 1'h0;
			age_r <= 3'h0;
		end else begin
			if (wr && wb_adr_i == rsrpc_pkg::ADR_SR_CTRL_TWO) two_r <= wb_dat_i[7:0];
			if (wr && wb_adr_i == rsrpc_pkg::ADR_PIPE_CTRL) pipe_r <= wb_dat_i[7:0] & 8'hEB;
			if (wr && wb_adr_i == rsrpc_pkg::ADR_MODE_CTRL) mode_r <= wb_dat_i[0];
			age_r <= wr ? 3'h0 : (age_r == 3'h7 ? age_r : age_r + 3'h1);
		end
	end
	AST_ACK_ONE: assert property (@(posedge clk) disable iff (!rstn)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	AST_ACK_DROP: assert property (@(posedge clk) disable iff (!rstn)
		wb_ack_o |=> !wb_ack_o) else $error("ack held");
	AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (!rstn)
		wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0) else $error("upper data");
	AST_CLOSE_2T: assert property (@(posedge clk) disable iff (!rstn)
		age_r == 3'h7 |-> page_close_2t == pipe_r[6]) else $error("page close");
	AST_CMD_2T: assert property (@(posedge clk) disable iff (!rstn)
		age_r == 3'h7 |-> cmd_sched_2t == pipe_r[5]) else $error("cmd sched");
	AST_PAGE_PIPE: assert property (@(posedge clk) disable iff (!rstn)
		age_r == 3'h7 |-> page_req_out == (pipe_r[7] ? $past(page_req_in, 2) :
		$past(page_req_in))) else $error("page pipe");
	AST_CKE_PIPE: assert property (@(posedge clk) disable iff (!rstn)
		age_r == 3'h7 |-> channel_a_clock_enable_out == ((mode_r & pipe_r[0]) ?
		$past(channel_a_clock_enable_in, 3) : (mode_r | pipe_r[0]) ?
		$past(channel_a_clock_enable_in, 2) : $past(channel_a_clock_enable_in)))
		else $error("cke pipe");
	AST_SR_EN: assert property (@(posedge clk) disable iff (!rstn)
		age_r == 3'h7 |-> (rank_in_self_refresh & ~two_r[3:0]) == 4'h0) else $error("sr en");
	AST_ACT_PRE: assert property (@(posedge clk) disable iff (!rstn)
		age_r == 3'h7 |-> act_pre_2t == pipe_r[3]) else $error("act pre");
	AST_CMD_PAIRED: assert property (@(posedge clk) disable iff (!rstn)
		age_r == 3'h7 && cmd_sched_2t |-> act_pre_2t) else $error("cmd 2t unpaired");
endmodule
bind rsrpc_top rsrpc_sva #(.PAGE_W(PAGE_W)) u_sva (
	.clk(clk),
	.rstn(rstn),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.channel_a_clock_enable_in(channel_a_clock_enable_in),
	.page_req_in(page_req_in),
	.rank_in_self_refresh(rank_in_self_refresh),
	.channel_a_clock_enable_out(channel_a_clock_enable_out),
	.page_req_out(page_req_out),
	.page_close_2t(page_close_2t),
	.cmd_sched_2t(cmd_sched_2t),
	.act_pre_2t(act_pre_2t)
);

//--- dv/rsrpc_rank_model.sv
// Far-side model of four DDR2 ranks on one channel.
// Assumes rank_in_self_refresh is a registered level.
`timescale 1ns/10ps
module rsrpc_rank_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] rank_in_self_refresh,
	output logic [3:0] auto_refresh_pulse
);
	logic [3:0] tick_r;
	// Held four cycles so the two-flop sync sees every refresh
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tick_r <= 4'h0;
			auto_refresh_pulse <= 4'h0;
		end else begin
			tick_r <= tick_r + 4'h1;
			auto_refresh_pulse <= (tick_r[3:2] == 2'h3) ? ~rank_in_self_refresh : 4'h0;
		end
	end
endmodule

//--- dv/tb.sv
// Self-checking bench for rsrpc_top over Wishbone.
// Assumes the rank model and the bound checker.
`timescale 1ns/10ps
module tb;
	localparam logic [7:0] CK = rsrpc_pkg::ADR_CHECK_CTRL;
	localparam logic [7:0] A2 = rsrpc_pkg::ADR_SR_CTRL_TWO;
	localparam logic [7:0] A3 = rsrpc_pkg::ADR_SR_CTRL_THREE;
	localparam logic [7:0] PP = rsrpc_pkg::ADR_PIPE_CTRL;
	logic clk, rstn, cyc, stb, we, ack, cke_i, fast, vbl, srq;
	logic [7:0] adr;
	logic [31:0] dat_w, dat_r;
	logic [3:0] arp, busy, in_sr, wake;
	logic [15:0] pg_i;
	int num_errors, cmp_count;
	rsrpc_top dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
		.fast_ddr2_support(fast), .auto_refresh_pulse(arp), .rank_busy(busy),
		.rank_wake_req(wake), .gfx_vblank(vbl), .sr_request(srq),
		.channel_a_clock_enable_in(cke_i), .page_req_in(pg_i), .rank_in_self_refresh(in_sr),
		.channel_a_clock_enable_out(), .page_req_out(), .page_close_2t(),
		.cmd_sched_2t(), .act_pre_2t());
	rsrpc_rank_model u_rank (.clk(clk), .rstn(rstn), .rank_in_self_refresh(in_sr),
		.auto_refresh_pulse(arp));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
		int i;
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat_w <= {24'h0, d};
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (ack !== 1'h1 && i < 20);
		if (ack !== 1'h1) begin
			num_errors++;
			results();
		end
		if (!w) chk(dat_r, {24'h0, e});
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
	endtask
	// Poll until match, or hold the full span to prove no entry
	task automatic sr(input logic [3:0] e, input logic poll);
		int i;
		for (i = 0; i < 300 && !(poll && in_sr === e); i++) @(posedge clk);
		chk({28'h0, in_sr}, {28'h0, e});
	endtask
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	// Sole driver of the pipe inputs; cleared while reset is held
	always @(posedge clk) begin
		if (!rstn) begin
			pg_i <= 16'h0000;
			cke_i <= 1'h0;
		end else begin
			pg_i <= pg_i + 16'h1;
			cke_i <= pg_i[1];
		end
	end
	initial begin
		{rstn, cyc, stb, we, fast, vbl, srq} = 7'h00;
		{adr, dat_w, busy, wake, num_errors, cmp_count} = '0;
		repeat (10) @(posedge clk);
		rstn <= 1'h1;
		bus(1'h0, CK, 8'h00, 8'h00);
		bus(1'h0, A2, 8'h00, 8'h10);
		bus(1'h0, A3, 8'h00, 8'h00);
		bus(1'h0, PP, 8'h00, 8'h00);
		bus(1'h1, PP, 8'hFF, 8'h00);
		bus(1'h0, PP, 8'h00, 8'hEB);
		bus(1'h1, A3, 8'hFF, 8'h00);
		bus(1'h0, A3, 8'h00, 8'h87);
		bus(1'h1, 8'h3C, 8'hFF, 8'h00);
		bus(1'h0, 8'h3C, 8'h00, 8'h00);
		for (int i = 0; i < 4; i++) begin
			bus(1'h1, rsrpc_pkg::ADR_MODE_CTRL, {7'h0, i[0]}, 8'h00);
			bus(1'h1, PP, (i[0] ? 8'hE8 : 8'h00) | {7'h0, i[1]}, 8'h00);
			repeat (10) @(posedge clk);
		end
		bus(1'h1, A2, 8'h21, 8'h00);
		sr(4'h1, 1'h1);
		bus(1'h0, rsrpc_pkg::ADR_STATUS, 8'h00, 8'h01);
		bus(1'h1, A2, 8'h20, 8'h00);
		sr(4'h0, 1'h1);
		bus(1'h1, CK, 8'h02, 8'h00);
		bus(1'h1, A2, 8'h21, 8'h00);
		sr(4'h0, 1'h0);
		vbl <= 1'h1;
		sr(4'h1, 1'h1);
		bus(1'h1, A2, 8'h20, 8'h00);
		bus(1'h1, CK, 8'h01, 8'h00);
		bus(1'h1, A2, 8'h21, 8'h00);
		sr(4'h0, 1'h0);
		srq <= 1'h1;
		sr(4'h1, 1'h1);
		bus(1'h1, A2, 8'h20, 8'h00);
		bus(1'h1, CK, 8'h00, 8'h00);
		fast <= 1'h1;
		busy <= 4'h2;
		bus(1'h1, A2, 8'hA3, 8'h00);
		sr(4'h0, 1'h0);
		busy <= 4'h0;
		sr(4'h3, 1'h1);
		// A wake on rank 0 alone must take rank 1 out with it
		wake <= 4'h1;
		sr(4'h0, 1'h1);
		results();
	end
endmodule
